// [rtl/rtc_pwc_pkg.sv]
// Purpose: Shared constants for the power window and timestamp block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Offsets are byte addresses
package rtc_pwc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_STAMP_A_TIME = 8'h10;
	localparam logic [7:0] OFF_STAMP_A_DATE = 8'h14;
	localparam logic [7:0] OFF_STAMP_B_TIME = 8'h18;
	localparam logic [7:0] OFF_STAMP_B_DATE = 8'h1C;
	// Control one fields
	localparam int BIT_STAMP_A_EN = 0;
	localparam int BIT_REPEAT_EN = 1;
	localparam int BIT_PIN_OE = 2;
	localparam int POS_PIN_SEL = 4;
	localparam int BIT_POLARITY = 9;
	localparam int BIT_PWC_EN = 10;
	localparam int BIT_CAL_EN = 15;
	localparam logic [2:0] PIN_SEL_POWER_CTL = 3'h3;
	// Control two and three fields
	localparam int POS_PRESCALE = 6;
	localparam int POS_STAB_LEN = 0;
	localparam int POS_SAMP_LEN = 8;
	localparam logic [7:0] WINDOW_OFF = 8'h00;
	localparam logic [7:0] WINDOW_ALWAYS = 8'hFF;
	// Status fields
	localparam int BIT_ST_CTL = 0;
	localparam int BIT_ST_STAB = 1;
	localparam int BIT_ST_SAMP = 2;
	localparam int BIT_ST_FLAG_A = 3;
	localparam int BIT_ST_FLAG_B = 4;
	// Reset values
	localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
	localparam logic [1:0] RST_PRESCALE = 2'h0;
	localparam logic [15:0] RST_CTRL_THREE = 16'h0000;
	// Prescaler masks
	localparam logic [7:0] MASK_DIV1 = 8'h00;
	localparam logic [7:0] MASK_DIV16 = 8'h0F;
	localparam logic [7:0] MASK_DIV64 = 8'h3F;
	localparam logic [7:0] MASK_DIV256 = 8'hFF;
	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STAB = 2'b01,
		SEQ_SAMP = 2'b10
	} seq_state_e;
endpackage

// [rtl/pin_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_q[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_q[i] <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [rtl/pwc_prescaler.sv]
// Purpose: Divides calendar ticks into power control ticks
// Assumes: cal_tick is a one-cycle pulse on pclk
// Notes: Ratio 1, 16, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module pwc_prescaler (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic [1:0] prescale,
	input wire logic cal_tick,
	// Output
	output logic pwc_tick
);
	logic [7:0] div_q;

	function automatic logic [7:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0: div_mask = rtc_pwc_pkg::MASK_DIV1;
			2'h1: div_mask = rtc_pwc_pkg::MASK_DIV16;
			2'h2: div_mask = rtc_pwc_pkg::MASK_DIV64;
			default: div_mask = rtc_pwc_pkg::MASK_DIV256;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else if (cal_tick) begin
			div_q <= div_q + 8'h01;
		end
	end

	assign pwc_tick = cal_tick && ((div_q | ~div_mask(prescale)) == 8'hFF);

	a_tick_from_cal: assert property (@(posedge pclk) disable iff (!presetn)
		pwc_tick |-> cal_tick)
		else $error("power control tick without calendar tick");
endmodule
`default_nettype wire

// [rtl/rtc_power_window.sv]
// Purpose: Power window sequencer and event timestamps behind APB
// Assumes: Calendar supplies time, date, ticks and periodic alarm
// Notes: Zero wait APB, read data registered in setup phase
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rtc_power_window (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Calendar side
	input wire logic cal_tick,
	input wire logic alarm_event,
	input wire logic [31:0] cur_time,
	input wire logic [31:0] cur_date,
	// Pins
	input wire logic tamper_input_pin,
	input wire logic supply_on_battery,
	output logic clock_pin_out,
	output logic clock_pin_oe,
	// Power control outputs and calendar interrupt
	output logic peripheral_power_control,
	output logic sample_gate,
	output logic stability_window,
	output logic calendar_irq
);
	logic [15:0] ctrl_one_q;
	logic [1:0] power_ctl_prescale;
	logic [15:0] ctrl_three_q;
	logic [31:0] stamp_a_time_q, stamp_a_date_q;
	logic [31:0] stamp_b_time_q, stamp_b_date_q;
	logic stamp_a_event_flag, stamp_b_flag_q, cap_a_pend_q;
	logic tamper_s, battery_s, tamper_prev_q, battery_prev_q;
	logic pwc_tick, ctl_active_q;
	logic [7:0] win_cnt_q;
	rtc_pwc_pkg::seq_state_e state_q;

	logic wr_en, rd_en, addr_ok;
	logic stamp_a_enable, periodic_repeat_enable, power_ctl_enable;
	logic calendar_enable, power_ctl_polarity, clock_pin_output_enable;
	logic [2:0] clock_pin_output_select;
	logic [7:0] sample_window_length, stability_window_length;
	logic tamper_fall, battery_rise, manual_req, start_a, set_a, set_b;
	logic clr_a, clr_b, win_done, start_cycle;
	logic [7:0] win_len;

	assign stamp_a_enable = ctrl_one_q[rtc_pwc_pkg::BIT_STAMP_A_EN];
	assign periodic_repeat_enable = ctrl_one_q[rtc_pwc_pkg::BIT_REPEAT_EN];
	assign clock_pin_output_enable = ctrl_one_q[rtc_pwc_pkg::BIT_PIN_OE];
	assign clock_pin_output_select =
		ctrl_one_q[rtc_pwc_pkg::POS_PIN_SEL +: 3];
	assign power_ctl_polarity = ctrl_one_q[rtc_pwc_pkg::BIT_POLARITY];
	assign power_ctl_enable = ctrl_one_q[rtc_pwc_pkg::BIT_PWC_EN];
	assign calendar_enable = ctrl_one_q[rtc_pwc_pkg::BIT_CAL_EN];
	assign sample_window_length = ctrl_three_q[rtc_pwc_pkg::POS_SAMP_LEN +: 8];
	assign stability_window_length =
		ctrl_three_q[rtc_pwc_pkg::POS_STAB_LEN +: 8];

	// APB decode
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign addr_ok = (paddr[1:0] == 2'h0) &&
		(paddr <= rtc_pwc_pkg::OFF_STAMP_B_DATE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (paddr)
				rtc_pwc_pkg::OFF_CTRL_ONE: prdata <= {16'h0000, ctrl_one_q};
				rtc_pwc_pkg::OFF_CTRL_TWO:
					prdata <= {24'h00_0000, power_ctl_prescale, 6'h00};
				rtc_pwc_pkg::OFF_CTRL_THREE: prdata <= {16'h0000, ctrl_three_q};
				rtc_pwc_pkg::OFF_STATUS:
					prdata <= {27'h000_0000, stamp_b_flag_q, stamp_a_event_flag,
						sample_gate, stability_window, ctl_active_q};
				rtc_pwc_pkg::OFF_STAMP_A_TIME: prdata <= stamp_a_time_q;
				rtc_pwc_pkg::OFF_STAMP_A_DATE: prdata <= stamp_a_date_q;
				rtc_pwc_pkg::OFF_STAMP_B_TIME: prdata <= stamp_b_time_q;
				rtc_pwc_pkg::OFF_STAMP_B_DATE: prdata <= stamp_b_date_q;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_q <= rtc_pwc_pkg::RST_CTRL_ONE;
			power_ctl_prescale <= rtc_pwc_pkg::RST_PRESCALE;
			ctrl_three_q <= rtc_pwc_pkg::RST_CTRL_THREE;
		end else if (wr_en) begin
			if (paddr == rtc_pwc_pkg::OFF_CTRL_ONE) begin
				ctrl_one_q <= pwdata[15:0];
			end
			if (paddr == rtc_pwc_pkg::OFF_CTRL_TWO) begin
				power_ctl_prescale <= pwdata[rtc_pwc_pkg::POS_PRESCALE +: 2];
			end
			if (paddr == rtc_pwc_pkg::OFF_CTRL_THREE) begin
				ctrl_three_q <= pwdata[15:0];
			end
		end
	end

	// Prescaler
	pwc_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.prescale(power_ctl_prescale),
		.cal_tick(cal_tick),
		.pwc_tick(pwc_tick)
	);

	// Sequencer
	assign start_cycle = alarm_event && periodic_repeat_enable &&
		calendar_enable && power_ctl_enable &&
		(state_q == rtc_pwc_pkg::SEQ_IDLE);
	assign win_len = (state_q == rtc_pwc_pkg::SEQ_STAB) ?
		stability_window_length : sample_window_length;
	assign win_done = pwc_tick && (win_cnt_q + 8'h01 >= win_len);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rtc_pwc_pkg::SEQ_IDLE;
			win_cnt_q <= 8'h00;
		end else begin
			case (state_q)
				rtc_pwc_pkg::SEQ_IDLE: begin
					win_cnt_q <= 8'h00;
					if (start_cycle) begin
						if (stability_window_length != rtc_pwc_pkg::WINDOW_OFF) begin
							state_q <= rtc_pwc_pkg::SEQ_STAB;
						end else if (sample_window_length !=
								rtc_pwc_pkg::WINDOW_OFF) begin
							state_q <= rtc_pwc_pkg::SEQ_SAMP;
						end
					end
				end
				rtc_pwc_pkg::SEQ_STAB: begin
					if (!power_ctl_enable) begin
						state_q <= rtc_pwc_pkg::SEQ_IDLE;
					end else if (win_done) begin
						win_cnt_q <= 8'h00;
						if (sample_window_length != rtc_pwc_pkg::WINDOW_OFF) begin
							state_q <= rtc_pwc_pkg::SEQ_SAMP;
						end else begin
							state_q <= rtc_pwc_pkg::SEQ_IDLE;
						end
					end else if (pwc_tick) begin
						win_cnt_q <= win_cnt_q + 8'h01;
					end
				end
				rtc_pwc_pkg::SEQ_SAMP: begin
					if (!power_ctl_enable || win_done) begin
						state_q <= rtc_pwc_pkg::SEQ_IDLE;
						win_cnt_q <= 8'h00;
					end else if (pwc_tick) begin
						win_cnt_q <= win_cnt_q + 8'h01;
					end
				end
				default: begin
					state_q <= rtc_pwc_pkg::SEQ_IDLE;
					win_cnt_q <= 8'h00;
				end
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_active_q <= 1'b0;
			sample_gate <= 1'b0;
			stability_window <= 1'b0;
			// Inactive level of the reset polarity keeps the peripheral off
			peripheral_power_control <=
				!rtc_pwc_pkg::RST_CTRL_ONE[rtc_pwc_pkg::BIT_POLARITY];
			clock_pin_out <=
				!rtc_pwc_pkg::RST_CTRL_ONE[rtc_pwc_pkg::BIT_POLARITY];
			clock_pin_oe <= 1'b0;
		end else begin
			ctl_active_q <= (state_q != rtc_pwc_pkg::SEQ_IDLE);
			sample_gate <= (state_q == rtc_pwc_pkg::SEQ_SAMP);
			stability_window <= (state_q == rtc_pwc_pkg::SEQ_STAB) ||
				(stability_window_length == rtc_pwc_pkg::WINDOW_ALWAYS);
			peripheral_power_control <= (state_q != rtc_pwc_pkg::SEQ_IDLE) ~^
				power_ctl_polarity;
			clock_pin_oe <= clock_pin_output_enable &&
				(clock_pin_output_select == rtc_pwc_pkg::PIN_SEL_POWER_CTL);
			clock_pin_out <= (state_q != rtc_pwc_pkg::SEQ_IDLE) ~^
				power_ctl_polarity;
		end
	end

	// Pin synchronisers and edges
	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({supply_on_battery, tamper_input_pin}),
		.sync_out({battery_s, tamper_s})
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Matches the synchroniser reset, so release shows no fall
			tamper_prev_q <= 1'b0;
			battery_prev_q <= 1'b0;
		end else begin
			tamper_prev_q <= tamper_s;
			battery_prev_q <= battery_s;
		end
	end

	assign tamper_fall = tamper_prev_q && !tamper_s;
	assign battery_rise = battery_s && !battery_prev_q;
	assign manual_req = wr_en && (paddr == rtc_pwc_pkg::OFF_STATUS) &&
		pwdata[rtc_pwc_pkg::BIT_ST_FLAG_A];
	assign start_a = stamp_a_enable && !stamp_a_event_flag && !cap_a_pend_q &&
		(tamper_fall || manual_req);
	assign set_a = cap_a_pend_q;
	assign set_b = battery_rise && !stamp_b_flag_q;
	assign clr_a = wr_en && (paddr == rtc_pwc_pkg::OFF_STATUS) &&
		!pwdata[rtc_pwc_pkg::BIT_ST_FLAG_A];
	assign clr_b = wr_en && (paddr == rtc_pwc_pkg::OFF_STATUS) &&
		!pwdata[rtc_pwc_pkg::BIT_ST_FLAG_B];

	// Timestamp A capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_a_pend_q <= 1'b0;
			stamp_a_time_q <= 32'h0000_0000;
			stamp_a_date_q <= 32'h0000_0000;
		end else begin
			cap_a_pend_q <= start_a;
			if (cap_a_pend_q) begin
				stamp_a_time_q <= cur_time;
				stamp_a_date_q <= cur_date;
			end
		end
	end

	// Timestamp B capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_b_time_q <= 32'h0000_0000;
			stamp_b_date_q <= 32'h0000_0000;
		end else if (set_b) begin
			stamp_b_time_q <= cur_time;
			stamp_b_date_q <= cur_date;
		end
	end

	// Flags, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_a_event_flag <= 1'b0;
			stamp_b_flag_q <= 1'b0;
			calendar_irq <= 1'b0;
		end else begin
			stamp_a_event_flag <= set_a || (stamp_a_event_flag && !clr_a);
			stamp_b_flag_q <= set_b || (stamp_b_flag_q && !clr_b);
			calendar_irq <= set_a || set_b;
		end
	end

	// Checks
	a_stab_to_samp: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == rtc_pwc_pkg::SEQ_STAB) && power_ctl_enable && win_done &&
		(sample_window_length != 8'h00)
		|=> state_q == rtc_pwc_pkg::SEQ_SAMP)
		else $error("sample window did not follow stability window");

	a_samp_closes: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == rtc_pwc_pkg::SEQ_SAMP) && win_done
		|=> ##1 !ctl_active_q && !sample_gate)
		else $error("windows not closed after sample window");

	a_pol_level: assert property (@(posedge pclk) disable iff (!presetn)
		$past(power_ctl_polarity) == power_ctl_polarity |->
		peripheral_power_control == (ctl_active_q ~^ power_ctl_polarity))
		else $error("control output level disagrees with polarity");

	a_stab_forever: assert property (@(posedge pclk) disable iff (!presetn)
		stability_window_length == 8'hFF [*2] |-> stability_window)
		else $error("stability window not held on");

	a_zero_stab: assert property (@(posedge pclk) disable iff (!presetn)
		start_cycle && (stability_window_length == 8'h00)
		|=> state_q != rtc_pwc_pkg::SEQ_STAB)
		else $error("zero stability window entered");

	a_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == rtc_pwc_pkg::SEQ_SAMP) && !win_done && power_ctl_enable
		|=> state_q == rtc_pwc_pkg::SEQ_SAMP)
		else $error("cycle restarted while windows open");

	a_manual_late: assert property (@(posedge pclk) disable iff (!presetn)
		manual_req && start_a |=> !stamp_a_event_flag ##1 stamp_a_event_flag)
		else $error("manual capture flag timing wrong");

	a_flag_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		stamp_a_event_flag |=> $stable(stamp_a_time_q))
		else $error("stamp changed while flag set");

	a_tamper_gate: assert property (@(posedge pclk) disable iff (!presetn)
		tamper_fall && !stamp_a_enable |=> !cap_a_pend_q)
		else $error("tamper accepted while disabled");

	a_irq_with_flag: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stamp_a_event_flag) |-> calendar_irq)
		else $error("no interrupt on timestamp");

	c_full_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		(state_q == rtc_pwc_pkg::SEQ_STAB) ##[1:1000]
		(state_q == rtc_pwc_pkg::SEQ_SAMP) ##[1:1000]
		(state_q == rtc_pwc_pkg::SEQ_IDLE));
	c_tamper_stamp: cover property (@(posedge pclk) disable iff (!presetn)
		tamper_fall && start_a ##2 stamp_a_event_flag);
	c_manual_stamp: cover property (@(posedge pclk) disable iff (!presetn)
		manual_req && start_a);
	c_battery_stamp: cover property (@(posedge pclk) disable iff (!presetn)
		set_b);
endmodule
`default_nettype wire

// [bench/periph_model.sv]
// Purpose: Peripheral powered through the switched supply
// Assumes: Powered while power control equals the polarity level
// Notes: Wake line is pulled up while unpowered, low once settled
`timescale 1ns/1ps
`default_nettype none
module periph_model #(
	parameter int SETTLE = 3
) (
	// Clock
	input wire logic pclk,
	// Supply
	input wire logic power,
	input wire logic polarity,
	// Wake
	output logic wake_n
);
	int up_cnt = 0;
	// Counts powered cycles, restarts when power drops
	always @(posedge pclk) begin
		if (power == polarity) begin
			up_cnt <= up_cnt + 1;
		end else begin
			up_cnt <= 0;
		end
	end
	assign wake_n = !(up_cnt > SETTLE);
endmodule
`default_nettype wire

// [bench/tb_rtc_power_window.sv]
// Purpose: Self-checking bench for the power window and timestamps
// Assumes: Calendar ticks every fourth cycle, zero wait APB
// Notes: Window lengths and stamp values drawn from an LFSR
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_power_window;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, cur_time = 32'h0, cur_date = 32'h0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, rerr, cal_tick = 0, alarm_event = 0;
	logic tb_tamper = 1, supply_on_battery = 0, pol = 0, wake_n, tamper;
	logic clock_pin_out, clock_pin_oe, peripheral_power_control;
	logic sample_gate, stability_window, calendar_irq;
	logic [15:0] lfsr = 16'h5E90;
	int n_mismatch = 0, cmp_count = 0, phase = 0;
	int stab_ticks = 0, samp_ticks = 0, irq_n = 0;
	assign tamper = tb_tamper & wake_n;
	rtc_power_window uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cal_tick(cal_tick), .alarm_event(alarm_event), .cur_time(cur_time),
		.cur_date(cur_date), .tamper_input_pin(tamper),
		.supply_on_battery(supply_on_battery), .clock_pin_out(clock_pin_out),
		.clock_pin_oe(clock_pin_oe),
		.peripheral_power_control(peripheral_power_control),
		.sample_gate(sample_gate), .stability_window(stability_window),
		.calendar_irq(calendar_irq));
	periph_model #(.SETTLE(3)) peri (.pclk(pclk),
		.power(peripheral_power_control), .polarity(pol), .wake_n(wake_n));
	always #12.5 pclk = ~pclk;
	// Calendar tick in every cycle whose phase is zero
	always @(posedge pclk) begin
		phase <= (phase + 1) % 4;
		cal_tick <= (phase == 3);
	end
	always @(negedge pclk) begin
		if (presetn) begin
			if (cal_tick && stability_window) stab_ticks++;
			if (cal_tick && sample_gate) samp_ticks++;
			if (calendar_irq) irq_n++;
			if (clock_pin_oe) chk_bit(clock_pin_out, peripheral_power_control);
			if (sample_gate) chk_bit(peripheral_power_control, pol);
		end
	end
	function automatic logic [15:0] nxt();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	function automatic int rnd(input int n);
		return nxt() % n + 1;
	endfunction
	task automatic chk_bit(input logic g, input logic e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t bit %b exp %b", $time, g, e);
		end
	endtask
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t value %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_rng(input int g, input int n, input int d);
		cmp_count++;
		if (g < (n ? d * (n - 1) + 1 : 0) || g > d * n) begin
			n_mismatch++;
			$display("mismatch %0t count %0d for %0d x %0d", $time, g, n, d);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// Alarm pulse placed so that the window opens away from a tick
	task automatic fire;
		do @(negedge pclk); while (phase != 0);
		@(posedge pclk);
		alarm_event <= 1;
		@(posedge pclk);
		alarm_event <= 0;
	endtask
	task automatic cyc(input logic [1:0] ps, input int s, input int p,
		input logic [15:0] c1);
		int d;
		d = 1 << (ps == 0 ? 0 : 2 * ps + 2);
		pol = c1[9];
		wr(rtc_pwc_pkg::OFF_CTRL_TWO, {24'h0, ps, 6'h00});
		wr(rtc_pwc_pkg::OFF_CTRL_THREE, {16'h0, p[7:0], s[7:0]});
		wr(rtc_pwc_pkg::OFF_CTRL_ONE, {16'h0, c1});
		// Pin enable is registered from the control register
		repeat (2) @(posedge pclk);
		chk_bit(clock_pin_oe, 1'b1);
		stab_ticks = 0;
		samp_ticks = 0;
		fire;
		if (s + p >= 2) fire;
		repeat ((s + p + 1) * d * 4 + 8) @(posedge pclk);
		if (!(c1[1] & c1[10] & c1[15])) begin
			s = 0;
			p = 0;
		end
		chk_rng(stab_ticks, s, d);
		chk_rng(samp_ticks, p, d);
		chk_bit(peripheral_power_control, !pol);
		wr(rtc_pwc_pkg::OFF_CTRL_ONE, 32'h0);
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge pclk);
		n_mismatch++;
		summarize;
	end
	initial begin
		logic [31:0] t0;
		int k;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		chk_bit(peripheral_power_control, 1'b1);
		rd(rtc_pwc_pkg::OFF_CTRL_ONE);
		chk_val(rdv, {16'h0, rtc_pwc_pkg::RST_CTRL_ONE});
		rd(rtc_pwc_pkg::OFF_CTRL_TWO);
		chk_val(rdv, {24'h0, rtc_pwc_pkg::RST_PRESCALE, 6'h00});
		rd(rtc_pwc_pkg::OFF_CTRL_THREE);
		chk_val(rdv, {16'h0, rtc_pwc_pkg::RST_CTRL_THREE});
		for (int i = 0; i < 2; i++) begin
			rd(i ? 8'h02 : 8'h20);
			chk_val(rdv, 32'h0);
			chk_bit(rerr, 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			cyc(i[1:0], rnd(2), rnd(2), 16'h8436 | {6'h0, i[0], 9'h0});
		end
		cyc(2'h0, rnd(8), rnd(8), 16'h8636);
		cyc(2'h0, 254, 1, 16'h8436);
		cyc(2'h0, 0, 3, 16'h8436);
		cyc(2'h0, 3, 0, 16'h8436);
		cyc(2'h0, 0, 0, 16'h8436);
		cyc(2'h0, 2, 2, 16'h8434);
		cyc(2'h0, 2, 2, 16'h0436);
		wr(rtc_pwc_pkg::OFF_CTRL_THREE, 32'hFF);
		repeat (4) @(posedge pclk);
		chk_bit(stability_window, 1'b1);
		wr(rtc_pwc_pkg::OFF_CTRL_THREE, 32'h0);
		rd(rtc_pwc_pkg::OFF_STATUS);
		chk_bit(rdv[3], 1'b0);
		pol = 0;
		cur_time <= {nxt(), nxt()};
		cur_date <= {nxt(), nxt()};
		supply_on_battery <= 1;
		repeat (8) @(posedge pclk);
		rd(rtc_pwc_pkg::OFF_STATUS);
		chk_bit(rdv[4], 1'b1);
		rd(rtc_pwc_pkg::OFF_STAMP_B_TIME);
		chk_val(rdv, cur_time);
		chk_rng(irq_n, 1, 1);
		wr(rtc_pwc_pkg::OFF_CTRL_ONE, 32'h1);
		tb_tamper <= 0;
		repeat (8) @(posedge pclk);
		rd(rtc_pwc_pkg::OFF_STATUS);
		chk_bit(rdv[3], 1'b1);
		rd(rtc_pwc_pkg::OFF_STAMP_A_TIME);
		chk_val(rdv, cur_time);
		rd(rtc_pwc_pkg::OFF_STAMP_A_DATE);
		chk_val(rdv, cur_date);
		t0 = cur_time;
		cur_time <= ~cur_time;
		tb_tamper <= 1;
		repeat (8) @(posedge pclk);
		tb_tamper <= 0;
		wr(rtc_pwc_pkg::OFF_STATUS, 32'h18);
		repeat (8) @(posedge pclk);
		rd(rtc_pwc_pkg::OFF_STAMP_A_TIME);
		chk_val(rdv, t0);
		chk_rng(irq_n, 2, 1);
		wr(rtc_pwc_pkg::OFF_STATUS, 32'h10);
		rd(rtc_pwc_pkg::OFF_STATUS);
		chk_bit(rdv[3], 1'b0);
		chk_bit(rdv[4], 1'b1);
		cur_time <= {nxt(), nxt()};
		wr(rtc_pwc_pkg::OFF_STATUS, 32'h18);
		// The write itself must not raise the interrupt in the cycle after it
		@(posedge pclk);
		chk_bit(calendar_irq, 1'b0);
		rd(rtc_pwc_pkg::OFF_STATUS);
		k = 0;
		do begin
			rd(rtc_pwc_pkg::OFF_STATUS);
			k++;
		end while (rdv[3] !== 1'b1 && k < 10);
		chk_bit(rdv[3], 1'b1);
		rd(rtc_pwc_pkg::OFF_STAMP_A_TIME);
		chk_val(rdv, cur_time);
		chk_rng(irq_n, 3, 1);
		wr(rtc_pwc_pkg::OFF_STATUS, 32'h10);
		wr(rtc_pwc_pkg::OFF_CTRL_ONE, 32'h0);
		wr(rtc_pwc_pkg::OFF_STATUS, 32'h18);
		repeat (6) @(posedge pclk);
		rd(rtc_pwc_pkg::OFF_STATUS);
		chk_bit(rdv[3], 1'b0);
		summarize;
	end
endmodule
`default_nettype wire
